// file: hw/irc_pkg.sv
`default_nettype none

package irc_pkg;

    // Register indices and byte addresses
    localparam logic [7:0] INFO_IDX = 8'h0e;
    localparam logic [7:0] CTRL_IDX = 8'h10;
    localparam logic [7:0] STAT_IDX = 8'h11;
    localparam logic [7:0] MASK_IDX = 8'h12;
    localparam logic [9:0] INFO_ADDR = {INFO_IDX, 2'b00};
    localparam logic [9:0] CTRL_ADDR = {CTRL_IDX, 2'b00};
    localparam logic [9:0] STAT_ADDR = {STAT_IDX, 2'b00};
    localparam logic [9:0] MASK_ADDR = {MASK_IDX, 2'b00};

    // Info register fields
    localparam int INFO_LIST_BIT = 15;
    localparam int INFO_BUF_BIT  = 14;
    localparam int INFO_IDX_MSB  = 5;
    localparam int IDX_W         = 6;

    // Control register fields
    localparam int CTRL_EN_BIT   = 0;
    localparam int CTRL_SR_BIT   = 1;
    localparam int CTRL_SOA_BIT  = 2;
    localparam int CTRL_STOP_IN_WAIT_BIT = 3;
    localparam int CTRL_W        = 4;

    // Status and mask fields
    localparam int ST_ABD_BIT = 0;
    localparam int ST_CON_BIT = 1;
    localparam int ST_EOL_BIT = 2;
    localparam int ST_W       = 3;

    // Reset values
    localparam logic [15:0] INFO_RST = 16'h0000;
    localparam logic [3:0]  CTRL_RST = 4'h0;
    localparam logic [2:0]  STAT_RST = 3'h0;
    localparam logic [2:0]  MASK_RST = 3'h0;

endpackage

`default_nettype wire

// file: hw/irc_capture.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RL1 - Clear info on soft reset or disable
// RL2 - Bit 15 captures active command list
// RL3 - Bit 14 captures active result buffer
// RL4 - Bits 5:0 capture index on events
// RL5 - Index sampled when result stored
// RL6 - Software abort sets done, last index
// RL7 - Store-on-abort one gives aborted index
// RL8 - Store-on-abort zero gives last stored
// RL9 - Idle abort keeps previous index
// RL10 - Hardware abort captures, no done flag
// RL11 - Writes ignored, bits 13:6 read zero
module irc_capture
(
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [9:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output var  logic [31:0] PRDATA,
    output var  logic        PREADY,
    output var  logic        PSLVERR,
    input  wire logic        CONV_FLAG_SET,
    input  wire logic        EOL_SET,
    input  wire logic        RESULT_STORE,
    input  wire logic [5:0]  RESULT_INDEX,
    input  wire logic [5:0]  CONV_INDEX,
    input  wire logic        CONV_BUSY,
    input  wire logic        ACTIVE_LIST,
    input  wire logic        ACTIVE_BUFFER,
    input  wire logic        SW_ABORT,
    input  wire logic        STOP_ENTRY,
    input  wire logic        WAIT_ENTRY,
    output var  logic        CONV_ENABLE,
    output var  logic        STORE_ON_ABORT,
    output var  logic        ABORT_DONE,
    output var  logic        IRQ
);

    localparam int W = irc_pkg::IDX_W;

    // Control and software-visible state
    logic [irc_pkg::CTRL_W-1:0] ctrl_ff;
    logic [irc_pkg::ST_W-1:0]   stat_ff;
    logic [irc_pkg::ST_W-1:0]   mask_ff;
    logic                       list_ff;
    logic                       buf_ff;
    logic [W-1:0]               idx_ff;
    logic [W-1:0]               last_ff;

    // Bus handshake state, done pulse and interrupt flops
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic        done_ff;
    logic        irq_ff;

    // Decoded controls
    logic         enabled;
    logic         clr_info;
    logic         hw_abort;
    logic         any_abort;
    logic         wr_hit;
    logic         acc;
    logic [W-1:0] stored_now;
    logic [W-1:0] nxt_idx;
    logic [3:0]   sel;

    // Access phase of an APB transfer
    assign acc    = PSEL && PENABLE;
    assign wr_hit = acc && pready_ff && PWRITE;

    assign enabled = ctrl_ff[irc_pkg::CTRL_EN_BIT];

    // RL1 clear condition
    assign clr_info = ctrl_ff[irc_pkg::CTRL_SR_BIT] || !enabled;

    // RL10 hardware abort sources
    assign hw_abort = STOP_ENTRY
        || (WAIT_ENTRY && ctrl_ff[irc_pkg::CTRL_STOP_IN_WAIT_BIT]);

    assign any_abort = SW_ABORT || hw_abort;

    // Decode of one register word address
    function automatic logic [3:0] dec(input logic [9:0] a);
        dec = {a == irc_pkg::MASK_ADDR,
               a == irc_pkg::STAT_ADDR,
               a == irc_pkg::CTRL_ADDR,
               a == irc_pkg::INFO_ADDR};
    endfunction

    // One-hot word select, decoded once for every user
    assign sel = dec(PADDR);

    // RL5 index of the store happening now, else the last stored index
    assign stored_now = RESULT_STORE ? RESULT_INDEX : last_ff;

    // Index selection; abort wins since it ends the list
    always_comb
    begin
        nxt_idx = idx_ff;
        if (any_abort)
        begin
            if (!CONV_BUSY)
                // RL9 idle abort keeps index
                nxt_idx = idx_ff;
            else if (hw_abort)
                // RL10 last stored index
                nxt_idx = stored_now;
            else if (ctrl_ff[irc_pkg::CTRL_SOA_BIT])
                // RL7 aborted conversion index
                nxt_idx = CONV_INDEX;
            else
                // RL8 last already stored
                nxt_idx = stored_now;
        end
        else if (CONV_FLAG_SET || EOL_SET)
            // RL4 capture on flag events
            nxt_idx = stored_now;
    end

    // Last stored result index tracker
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            last_ff <= '0;
        else if (clr_info)
            last_ff <= '0;
        else if (RESULT_STORE)
            // RL5 sample at store time
            last_ff <= RESULT_INDEX;
    end

    // Captured index field
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            idx_ff <= irc_pkg::INFO_RST[W-1:0];
        else if (clr_info)
            // RL1 cleared while off
            idx_ff <= '0;
        else
            idx_ff <= nxt_idx;
    end

    // Captured list and buffer bits
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            list_ff <= irc_pkg::INFO_RST[irc_pkg::INFO_LIST_BIT];
            buf_ff  <= irc_pkg::INFO_RST[irc_pkg::INFO_BUF_BIT];
        end
        else if (clr_info)
        begin
            list_ff <= 1'b0;
            buf_ff  <= 1'b0;
        end
        else if (CONV_FLAG_SET || any_abort)
        begin
            // RL2 active list
            list_ff <= ACTIVE_LIST;
            // RL3 active buffer
            buf_ff  <= ACTIVE_BUFFER;
        end
    end

    // Control register, software written
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            ctrl_ff <= irc_pkg::CTRL_RST;
        else if (wr_hit && sel[1])
            ctrl_ff <= PWDATA[irc_pkg::CTRL_W-1:0];
    end

    // Mask register
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            mask_ff <= irc_pkg::MASK_RST;
        else if (wr_hit && sel[3])
            mask_ff <= PWDATA[irc_pkg::ST_W-1:0];
    end

    // Sticky status; a set in the clear cycle wins
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            stat_ff <= irc_pkg::STAT_RST;
        else
        begin
            stat_ff <= (stat_ff
                & ~((wr_hit && sel[2])
                    ? PWDATA[irc_pkg::ST_W-1:0]
                    : '0))
                | {EOL_SET && enabled,
                   CONV_FLAG_SET && enabled,
                   // RL6 software abort done flag
                   SW_ABORT && enabled};
        end
    end

    // Done pulse; hardware aborts never raise it
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            done_ff <= 1'b0;
        else
            // RL10 only software abort
            done_ff <= SW_ABORT && enabled;
    end

    // Level interrupt from unmasked status
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(stat_ff & mask_ff);
    end

    // One wait state so read data comes from a flop
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
            pready_ff <= 1'b0;
        else
            pready_ff <= acc && !pready_ff;
    end

    // Read data and error for unmapped words
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end
        else if (acc && !pready_ff)
        begin
            pslverr_ff <= sel == 4'h0;
            prdata_ff  <= '0;
            unique case (1'b1)
                sel[0]:
                    // RL11 read only, gap reads zero
                    prdata_ff <= {16'h0000, list_ff, buf_ff,
                                  8'h00, idx_ff};
                sel[1]:
                    prdata_ff <= {28'h0000000, ctrl_ff};
                sel[2]:
                    prdata_ff <= {29'h0000000, stat_ff};
                sel[3]:
                    prdata_ff <= {29'h0000000, mask_ff};
                default:
                    prdata_ff <= '0;
            endcase
        end
        else
        begin
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end
    end

    // Ports straight from flops
    assign PREADY         = pready_ff;
    assign PSLVERR        = pslverr_ff;
    assign PRDATA         = prdata_ff;
    assign ABORT_DONE     = done_ff;
    assign IRQ            = irq_ff;
    assign CONV_ENABLE    = ctrl_ff[irc_pkg::CTRL_EN_BIT];
    assign STORE_ON_ABORT = ctrl_ff[irc_pkg::CTRL_SOA_BIT];

    // Checks on the capture behaviour
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    // RL1 cleared while off
    clear_off_a: assert property (clr_info |=> idx_ff == '0 // RL1
        && !list_ff && !buf_ff)
        else $error("info not cleared");
    // RL2 list on flag
    list_cap_a: assert property (!clr_info && CONV_FLAG_SET // RL2
        |=> list_ff == $past(ACTIVE_LIST))
        else $error("list not captured");
    // RL3 buffer on abort
    buf_cap_a: assert property (!clr_info && any_abort // RL3
        |=> buf_ff == $past(ACTIVE_BUFFER))
        else $error("buffer not captured");
    // RL4 index on end-of-list
    eol_idx_a: assert property (!clr_info && EOL_SET && !any_abort // RL4
        && RESULT_STORE |=> idx_ff == $past(RESULT_INDEX))
        else $error("eol index wrong");
    // RL7 aborted conversion index
    soa_one_a: assert property (!clr_info && SW_ABORT && CONV_BUSY // RL7
        && ctrl_ff[irc_pkg::CTRL_SOA_BIT]
        |=> idx_ff == $past(CONV_INDEX))
        else $error("aborted index wrong");
    // RL8 last stored index
    soa_zero_a: assert property (!clr_info && SW_ABORT && CONV_BUSY // RL8
        && !ctrl_ff[irc_pkg::CTRL_SOA_BIT] && !RESULT_STORE
        |=> idx_ff == $past(last_ff))
        else $error("last stored index wrong");
    // RL9 idle abort keeps
    idle_keep_a: assert property (!clr_info && any_abort // RL9
        && !CONV_BUSY |=> $stable(idx_ff))
        else $error("idle abort changed index");
    // RL10 no done pulse
    hw_noflag_a: assert property (hw_abort && !SW_ABORT // RL10
        |=> !done_ff)
        else $error("hw abort raised done");
    // RL6 done flag set
    sw_done_a: assert property (SW_ABORT && enabled // RL6
        |=> done_ff ##1 stat_ff[irc_pkg::ST_ABD_BIT]
            || $past(wr_hit))
        else $error("done flag missing");
    // RL11 writes ignored
    ro_info_a: assert property (wr_hit && sel[0] // RL11
        && !any_abort && !CONV_FLAG_SET && !EOL_SET && !clr_info
        |=> $stable(idx_ff))
        else $error("info written");
    // RL11 gap bits zero
    rd_gap_a: assert property (acc && !pready_ff && sel[0] // RL11
        |=> PRDATA[31:16] == 16'h0000 && PRDATA[13:6] == 8'h00)
        else $error("info gap not zero");
    // RL5 sampled at store
    store_seen_a: assert property (RESULT_STORE && !clr_info // RL5
        |=> last_ff == $past(RESULT_INDEX))
        else $error("store not sampled");
    apb_ans_a: assert property (acc && !pready_ff |=> pready_ff)
        else $error("no answer");
    // Interrupt follows unmasked status one cycle later
    irq_set_a: assert property (|(stat_ff & mask_ff) |=> IRQ)
        else $error("irq not raised");
    irq_clr_a: assert property (!(|(stat_ff & mask_ff)) |=> !IRQ)
        else $error("irq not lowered");

    conv_cov: cover property (CONV_FLAG_SET && enabled ##2 IRQ);
    abort_cov: cover property (SW_ABORT && CONV_BUSY && enabled);
    hw_cov: cover property (hw_abort && CONV_BUSY && enabled);
    idle_cov: cover property (any_abort && !CONV_BUSY && enabled);

endmodule

`default_nettype wire

// file: verif/test_irc_capture.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module test_irc_capture;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [9:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        flag, eol, store, busy, lst, bsel, sw_ab, stop_e, wait_e;
    logic        conv_en, soa, done, irq, x_l, x_b;
    logic [5:0]  ridx, cidx, last, x_idx;
    int          err_count, checks, dones, seed, k;

    irc_capture u_irc_capture
    (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .CONV_FLAG_SET(flag),
        .EOL_SET(eol), .RESULT_STORE(store), .RESULT_INDEX(ridx),
        .CONV_INDEX(cidx), .CONV_BUSY(busy), .ACTIVE_LIST(lst),
        .ACTIVE_BUFFER(bsel), .SW_ABORT(sw_ab), .STOP_ENTRY(stop_e),
        .WAIT_ENTRY(wait_e), .CONV_ENABLE(conv_en),
        .STORE_ON_ABORT(soa), .ABORT_DONE(done), .IRQ(irq)
    );

    // Clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Done pulses counted mid-cycle, away from the launching edge
    always @(negedge clk)
        if (done === 1'b1)
            dones++;

    // Expected register image
    function automatic logic [31:0] info_f(input logic l, input logic b,
                                           input logic [5:0] i);
        info_f = {16'h0000, l, b, 8'h00, i};
    endfunction

    task automatic report_and_stop();
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One APB transfer; request held until pready seen high
    task automatic apb(input logic w, input logic [9:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Ready seen as it stands at the edge, before the edge updates it
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                $display("MISMATCH %0t no ready", $time);
                report_and_stop();
            end
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk_info();
        apb(1'b0, irc_pkg::INFO_ADDR, 32'h0);
        `CHK(rd, info_f(x_l, x_b, x_idx))
    endtask

    task automatic chk_irq(input logic e);
        @(negedge clk);
        `CHK(irq, e)
        @(posedge clk);
    endtask

    // One-cycle sequencer event; ab: 1 software, 2 stop, 3 wait
    task automatic ev(input logic f, input logic e, input logic s,
                      input logic [1:0] ab, input logic [5:0] i);
        flag   <= f;
        eol    <= e;
        store  <= s;
        ridx   <= i;
        sw_ab  <= (ab == 2'd1);
        stop_e <= (ab == 2'd2);
        wait_e <= (ab == 2'd3);
        @(posedge clk);
        {flag, eol, store, sw_ab, stop_e, wait_e} <= 6'h00;
        @(posedge clk);
        if (s)
            last = i;
    endtask

    // Main sequence
    initial
    begin
        {psel, penable, pwrite, flag, eol, store, busy, lst} = 8'h00;
        {bsel, sw_ab, stop_e, wait_e, rst_n} = 5'h00;
        {paddr, pwdata, ridx, cidx, last, x_idx, x_l, x_b} = '0;
        err_count = 0;
        checks = 0;
        dones = 0;
        seed = 79;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        ev(1'b1, 1'b0, 1'b1, 2'd0, 6'h2a);
        chk_info();
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h1);
        `CHK(conv_en, 1'b1)
        // Random captures; index differs from the converting one
        for (int j = 0; j < 12; j++)
        begin
            k = $random(seed);
            lst  <= k[8];
            bsel <= k[9];
            cidx <= ~k[5:0];
            x_idx = (j == 0) ? 6'h3f : k[5:0];
            if (!k[6] || j == 0)
                {x_l, x_b} = k[9:8] >> 0 == 0 ? 2'b00 : {k[8], k[9]};
            ev(!k[6] || j == 0, k[6] | k[7], 1'b1, 2'd0, x_idx);
            chk_info();
        end
        apb(1'b1, irc_pkg::INFO_ADDR, 32'hffffffff);
        chk_info();
        // Abort of a running conversion, store-on-abort set
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h5);
        `CHK(soa, 1'b1)
        busy <= 1'b1;
        cidx <= 6'h15;
        lst  <= ~x_l;
        bsel <= ~x_b;
        {x_l, x_b, x_idx} = {~x_l, ~x_b, 6'h15};
        ev(1'b0, 1'b0, 1'b0, 2'd1, 6'h00);
        chk_info();
        `CHK(dones, 1)
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h1);
        `CHK(soa, 1'b0)
        x_idx = last;
        ev(1'b0, 1'b0, 1'b0, 2'd1, 6'h00);
        chk_info();
        // Idle abort keeps the index but takes the changed list
        busy <= 1'b0;
        lst  <= ~x_l;
        x_l = ~x_l;
        ev(1'b0, 1'b0, 1'b0, 2'd1, 6'h00);
        chk_info();
        // Hardware aborts: no done pulse, wait needs stop-in-wait
        busy <= 1'b1;
        ev(1'b0, 1'b0, 1'b1, 2'd0, 6'h07);
        ev(1'b0, 1'b0, 1'b0, 2'd2, 6'h00);
        x_idx = 6'h07;
        chk_info();
        ev(1'b0, 1'b0, 1'b1, 2'd3, 6'h09);
        chk_info();
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h9);
        ev(1'b0, 1'b0, 1'b0, 2'd3, 6'h00);
        x_idx = 6'h09;
        chk_info();
        `CHK(dones, 3)
        // Interrupt raised, masked, cleared
        apb(1'b1, irc_pkg::STAT_ADDR, 32'h7);
        apb(1'b1, irc_pkg::MASK_ADDR, 32'h2);
        chk_irq(1'b0);
        ev(1'b1, 1'b0, 1'b1, 2'd0, 6'h11);
        chk_irq(1'b1);
        apb(1'b0, irc_pkg::STAT_ADDR, 32'h0);
        `CHK(rd, 32'h2)
        apb(1'b1, irc_pkg::MASK_ADDR, 32'h0);
        chk_irq(1'b0);
        apb(1'b1, irc_pkg::MASK_ADDR, 32'h2);
        chk_irq(1'b1);
        apb(1'b1, irc_pkg::STAT_ADDR, 32'h2);
        chk_irq(1'b0);
        apb(1'b0, 10'h3fc, 32'h0);
        `CHK(err, 1'b1)
        `CHK(rd, 32'h0)
        // Soft reset and disable both clear the register
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h3);
        {x_l, x_b, x_idx} = '0;
        chk_info();
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h1);
        ev(1'b1, 1'b0, 1'b1, 2'd0, 6'h22);
        apb(1'b1, irc_pkg::CTRL_ADDR, 32'h0);
        `CHK(conv_en, 1'b0)
        chk_info();
        report_and_stop();
    end
endmodule

`default_nettype wire
